// ---- hdl/ces_pkg.sv ----
// Shared constants, enumerations and carrier types of the exception sequencer
package ces_pkg;

  // Exception kinds; the code times four is the vector byte address
  typedef enum logic [2:0] {
    EXC_RESET  = 3'b000,
    EXC_UNDEF  = 3'b001,
    EXC_SWTRAP = 3'b010,
    EXC_PABT   = 3'b011,
    EXC_DABT   = 3'b100,
    EXC_RSVD   = 3'b101,
    EXC_IRQ    = 3'b110,
    EXC_FIQ    = 3'b111
  } ces_exc_t;

  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_SWTRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT = 32'h0000_000c;
  localparam logic [31:0] VEC_DABT = 32'h0000_0010;
  localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001c;

  // Processor modes
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;

  // Status word fields
  localparam int ST_MODE_MSB = 4;
  localparam int ST_T_BIT = 5;
  localparam int ST_F_BIT = 6;
  localparam int ST_I_BIT = 7;

  // Banked link/saved-status slots
  localparam int NUM_BANKS = 5;
  localparam logic [2:0] BANK_SVC = 3'h0;
  localparam logic [2:0] BANK_UND = 3'h1;
  localparam logic [2:0] BANK_ABT = 3'h2;
  localparam logic [2:0] BANK_IRQ = 3'h3;
  localparam logic [2:0] BANK_FIQ = 3'h4;
  localparam logic [2:0] BANK_NONE = 3'h7;

  // Address steps and return offsets
  localparam logic [31:0] STEP_FULL = 32'h0000_0004;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] DABT_LINK_OFF = 32'h0000_0008;

  // Trap-return decodings: flag-setting move or subtract of the link into the PC
  localparam logic [7:0] RET_MOVS_OP = 8'h1b;
  localparam logic [7:0] RET_SUBS_OP = 8'h25;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [3:0] REG_LR = 4'he;
  localparam logic [11:0] RET_MOVS_OPND = 12'h00e;

  // Timing in processor cycles
  localparam int T_SYNC_MIN = 2;
  localparam int T_SYNC_MAX = 3;
  localparam int T_LDM = 20;
  localparam int T_DABT_ENTRY = 3;
  localparam int T_FIQ_ENTRY = 2;
  localparam int T_OTHER_ENTRY = 2;
  localparam int FIQ_LAT_MAX = T_SYNC_MAX + T_LDM + T_DABT_ENTRY + T_FIQ_ENTRY;
  localparam int IRQ_LAT_MIN = T_SYNC_MIN + T_FIQ_ENTRY;
  localparam logic [2:0] CNT_DABT = 3'(T_DABT_ENTRY - 2);
  localparam logic [2:0] CNT_FIQ = 3'(T_FIQ_ENTRY - 2);
  localparam logic [2:0] CNT_OTHER = 3'(T_OTHER_ENTRY - 2);

  // Register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_LINK = 8'h04;
  localparam logic [7:0] REG_SAVED = 8'h08;
  localparam logic [7:0] REG_CAUSE = 8'h0c;

  typedef enum logic [3:0] {
    CLS_DATAPROC = 4'h0,
    CLS_MULTIPLY = 4'h1,
    CLS_SWAP     = 4'h2,
    CLS_BXCHG    = 4'h3,
    CLS_HALFWORD = 4'h4,
    CLS_SINGLE   = 4'h5,
    CLS_BLOCK    = 4'h6,
    CLS_BRANCH   = 4'h7,
    CLS_COPROC   = 4'h8,
    CLS_UNDEF    = 4'h9,
    CLS_SWTRAP   = 4'ha
  } ces_class_t;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_RUN   = 2'b01,
    ST_ENTRY = 2'b10
  } ces_state_t;

  // Instruction offered at the head of the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [31:0] pc;
    logic pabt;
    logic busy;
  } ces_insn_t;

  typedef struct packed {
    ces_state_t state;
    logic [31:0] pc;
    logic [31:0] status;
    logic [NUM_BANKS-1:0][31:0] link;
    logic [NUM_BANKS-1:0][31:0] saved;
    ces_exc_t kind;
    logic [2:0] cnt;
    logic chainFiq;
    logic [31:0] fetchAddr;
    logic fetchValid;
    logic excEntry;
    logic wbAck;
    logic [31:0] wbDat;
  } ces_seq_t;

endpackage

// ---- hdl/ces_req_sync.sv ----
// Two-stage synchroniser for the active-low interrupt request lines
`timescale 1ns/100ps
`default_nettype none
module ces_req_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Raw and synchronised requests, active low
  input wire logic [WIDTH-1:0] reqLow,
  output logic [WIDTH-1:0] syncLow
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ces_sync_t;

  ces_sync_t sync_r;
  ces_sync_t sync_nxt;

  always_comb begin
    sync_nxt = sync_r;
    sync_nxt.meta = reqLow;
    sync_nxt.stable = sync_r.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= '1;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign syncLow = sync_r.stable;

endmodule // ces_req_sync
`default_nettype wire

// ---- hdl/ces_insn_classify.sv ----
// Top-level format classification of an instruction word
`timescale 1ns/100ps
`default_nettype none
module ces_insn_classify (
  // Instruction word in, class out
  input wire logic [31:0] word,
  output ces_pkg::ces_class_t cls
);

  always_comb begin
    // Overlapping decodings taken in priority order; an encoding lands in exactly one class
    if (word[27:24] == 4'hf) begin
      cls = ces_pkg::CLS_SWTRAP;
    end else if (word[27:26] == 2'h3) begin
      cls = ces_pkg::CLS_COPROC;
    end else if (word[27:25] == 3'h5) begin
      cls = ces_pkg::CLS_BRANCH;
    end else if (word[27:25] == 3'h4) begin
      cls = ces_pkg::CLS_BLOCK;
    end else if (word[27:25] == 3'h3 && word[4]) begin
      cls = ces_pkg::CLS_UNDEF;
    end else if (word[27:26] == 2'h1) begin
      cls = ces_pkg::CLS_SINGLE;
    end else if (word[27:4] == 24'h12fff1) begin
      cls = ces_pkg::CLS_BXCHG;
    end else if (word[27:23] == 5'h02 && word[21:20] == 2'h0 && word[11:4] == 8'h09) begin
      cls = ces_pkg::CLS_SWAP;
    end else if (word[27:24] == 4'h0 && word[7:4] == 4'h9) begin
      cls = ces_pkg::CLS_MULTIPLY;
    end else if (word[27:25] == 3'h0 && word[7] && word[4]) begin
      // Unallocated forms such as a multiply with bit 6 set land here, never trap
      cls = ces_pkg::CLS_HALFWORD;
    end else begin
      cls = ces_pkg::CLS_DATAPROC;
    end
  end

endmodule // ces_insn_classify
`default_nettype wire

// ---- hdl/ces_exception_sequencer.sv ----
// Exception sequencer: priority, vectoring, entry/return and core reset sequencing
`timescale 1ns/100ps
`default_nettype none
module ces_exception_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Core reset request, active low, synchronous
  input wire logic resetInputActiveLow,
  // Instruction at the head of the pipeline
  input wire ces_pkg::ces_insn_t insn,
  // Data abort from the memory system
  input wire logic dabtIn,
  input wire logic [31:0] dabtPc,
  // Interrupt requests, active low
  input wire logic fastIrqRequestLow,
  input wire logic normalIrqRequestLow,
  // Fetch redirect and state
  output logic [31:0] fetchAddr,
  output logic fetchValid,
  output logic [31:0] currentStatusWord,
  output logic excEntry,
  output ces_pkg::ces_exc_t excKind,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ces_pkg::ces_seq_t seq_r;
  ces_pkg::ces_seq_t seq_nxt;
  ces_pkg::ces_class_t insnCls;
  logic [1:0] reqSyncLow;
  logic fiqPend;
  logic irqPend;
  logic [2:0] curBank;
  logic [31:0] step;
  logic [31:0] retAddr;

  ces_insn_classify u_classify (
    .word(insn.word),
    .cls(insnCls)
  );

  // Two-flop delay sets the interrupt latency bounds
  ces_req_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .reqLow({fastIrqRequestLow, normalIrqRequestLow}),
    .syncLow(reqSyncLow)
  );

  function automatic logic [4:0] modeOf(input ces_pkg::ces_exc_t k);
    unique case (k)
      ces_pkg::EXC_UNDEF: modeOf = ces_pkg::MODE_UND;
      ces_pkg::EXC_PABT, ces_pkg::EXC_DABT: modeOf = ces_pkg::MODE_ABT;
      ces_pkg::EXC_IRQ: modeOf = ces_pkg::MODE_IRQ;
      ces_pkg::EXC_FIQ: modeOf = ces_pkg::MODE_FIQ;
      default: modeOf = ces_pkg::MODE_SVC;
    endcase
  endfunction

  function automatic logic [2:0] bankOf(input logic [4:0] mode);
    unique case (mode)
      ces_pkg::MODE_SVC: bankOf = ces_pkg::BANK_SVC;
      ces_pkg::MODE_UND: bankOf = ces_pkg::BANK_UND;
      ces_pkg::MODE_ABT: bankOf = ces_pkg::BANK_ABT;
      ces_pkg::MODE_IRQ: bankOf = ces_pkg::BANK_IRQ;
      ces_pkg::MODE_FIQ: bankOf = ces_pkg::BANK_FIQ;
      default: bankOf = ces_pkg::BANK_NONE;
    endcase
  endfunction

  function automatic logic [31:0] vecOf(input ces_pkg::ces_exc_t k);
    unique case (k)
      ces_pkg::EXC_RESET: vecOf = ces_pkg::VEC_RESET;
      ces_pkg::EXC_UNDEF: vecOf = ces_pkg::VEC_UNDEF;
      ces_pkg::EXC_SWTRAP: vecOf = ces_pkg::VEC_SWTRAP;
      ces_pkg::EXC_PABT: vecOf = ces_pkg::VEC_PABT;
      ces_pkg::EXC_DABT: vecOf = ces_pkg::VEC_DABT;
      ces_pkg::EXC_RSVD: vecOf = ces_pkg::VEC_RSVD;
      ces_pkg::EXC_IRQ: vecOf = ces_pkg::VEC_IRQ;
      ces_pkg::EXC_FIQ: vecOf = ces_pkg::VEC_FIQ;
    endcase
  endfunction

  function automatic logic isReturn(input logic [31:0] w);
    isReturn = (w[15:12] == ces_pkg::REG_PC) &&
      ((w[27:20] == ces_pkg::RET_MOVS_OP && w[11:0] == ces_pkg::RET_MOVS_OPND) ||
       (w[27:20] == ces_pkg::RET_SUBS_OP && w[19:16] == ces_pkg::REG_LR &&
        w[11:8] == 4'h0));
  endfunction

  // Start an exception entry on top of the next-state copy s
  function automatic ces_pkg::ces_seq_t enterExc(input ces_pkg::ces_seq_t s,
                                                 input ces_pkg::ces_exc_t k,
                                                 input logic [31:0] ret);
    logic [2:0] b;
    b = bankOf(modeOf(k));
    s.link[b] = ret;
    s.saved[b] = s.status;
    s.status[ces_pkg::ST_MODE_MSB:0] = modeOf(k);
    s.status[ces_pkg::ST_I_BIT] = 1'b1;
    if (k == ces_pkg::EXC_FIQ) begin
      s.status[ces_pkg::ST_F_BIT] = 1'b1;
    end
    s.status[ces_pkg::ST_T_BIT] = 1'b0;
    s.kind = k;
    s.excEntry = 1'b1;
    s.state = ces_pkg::ST_ENTRY;
    if (k == ces_pkg::EXC_DABT) begin
      s.cnt = ces_pkg::CNT_DABT;
    end else if (k == ces_pkg::EXC_FIQ) begin
      s.cnt = ces_pkg::CNT_FIQ;
    end else begin
      s.cnt = ces_pkg::CNT_OTHER;
    end
    enterExc = s;
  endfunction

  always_comb begin
    seq_nxt = seq_r;
    seq_nxt.fetchValid = 1'b0;
    seq_nxt.excEntry = 1'b0;
    seq_nxt.wbAck = 1'b0;
    curBank = bankOf(seq_r.status[ces_pkg::ST_MODE_MSB:0]);
    step = seq_r.status[ces_pkg::ST_T_BIT] ? ces_pkg::STEP_HALF : ces_pkg::STEP_FULL;
    fiqPend = !reqSyncLow[1] && !seq_r.status[ces_pkg::ST_F_BIT];
    irqPend = !reqSyncLow[0] && !seq_r.status[ces_pkg::ST_I_BIT];
    retAddr = seq_r.link[curBank] - (insn.word[25] ? {24'h0, insn.word[7:0]} : 32'h0);

    // Status write lands first so that hardware updates below win
    if (seq_r.wbAck && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ces_pkg::REG_STATUS) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          seq_nxt.status[i*8 +: 8] = wb_dat_i[i*8 +: 8];
        end
      end
    end

    unique case (seq_r.state)
      ces_pkg::ST_HOLD: begin
        seq_nxt.link[ces_pkg::BANK_SVC] = seq_r.fetchAddr;
        seq_nxt.saved[ces_pkg::BANK_SVC] = seq_r.status;
        seq_nxt.status[ces_pkg::ST_MODE_MSB:0] = ces_pkg::MODE_SVC;
        seq_nxt.status[ces_pkg::ST_I_BIT] = 1'b1;
        seq_nxt.status[ces_pkg::ST_F_BIT] = 1'b1;
        seq_nxt.status[ces_pkg::ST_T_BIT] = 1'b0;
        seq_nxt.fetchAddr = ces_pkg::VEC_RESET;
        seq_nxt.pc = ces_pkg::VEC_RESET;
        seq_nxt.fetchValid = 1'b1;
        seq_nxt.kind = ces_pkg::EXC_RESET;
        seq_nxt.excEntry = 1'b1;
        seq_nxt.state = ces_pkg::ST_RUN;
      end
      ces_pkg::ST_RUN: begin
        if (dabtIn) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_DABT, dabtPc + ces_pkg::DABT_LINK_OFF);
          seq_nxt.chainFiq = fiqPend;
        end else if (!insn.busy && fiqPend) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_FIQ, seq_r.pc + ces_pkg::STEP_FULL);
        end else if (!insn.busy && irqPend) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_IRQ, seq_r.pc + ces_pkg::STEP_FULL);
        end else if (insn.valid && insn.pabt) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_PABT, insn.pc + ces_pkg::STEP_FULL);
        end else if (insn.valid && insnCls == ces_pkg::CLS_UNDEF) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_UNDEF, insn.pc + step);
        end else if (insn.valid && insnCls == ces_pkg::CLS_SWTRAP) begin
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_SWTRAP, insn.pc + step);
        end else if (insn.valid && insnCls == ces_pkg::CLS_DATAPROC && isReturn(insn.word) &&
                     curBank != ces_pkg::BANK_NONE) begin
          seq_nxt.status = seq_r.saved[curBank];
          seq_nxt.fetchAddr = retAddr;
          seq_nxt.pc = retAddr;
          seq_nxt.fetchValid = 1'b1;
        end else if (insn.valid) begin
          seq_nxt.pc = insn.pc + step;
        end
      end
      ces_pkg::ST_ENTRY: begin
        if (seq_r.cnt != 3'h0) begin
          seq_nxt.cnt = seq_r.cnt - 3'h1;
        end else if (seq_r.chainFiq) begin
          // Fast interrupt return lands on the abort handler's first instruction
          seq_nxt = enterExc(seq_nxt, ces_pkg::EXC_FIQ, ces_pkg::VEC_DABT + ces_pkg::STEP_FULL);
          seq_nxt.chainFiq = 1'b0;
        end else begin
          seq_nxt.fetchAddr = vecOf(seq_r.kind);
          seq_nxt.pc = vecOf(seq_r.kind);
          seq_nxt.fetchValid = 1'b1;
          seq_nxt.state = ces_pkg::ST_RUN;
        end
      end
      default: begin
        seq_nxt.state = ces_pkg::ST_HOLD;
      end
    endcase

    // Core reset abandons everything and walks the fetch address
    if (!resetInputActiveLow) begin
      seq_nxt = seq_r;
      seq_nxt.state = ces_pkg::ST_HOLD;
      seq_nxt.chainFiq = 1'b0;
      seq_nxt.excEntry = 1'b0;
      seq_nxt.wbAck = 1'b0;
      seq_nxt.fetchAddr = seq_r.fetchAddr + ces_pkg::STEP_FULL;
      seq_nxt.fetchValid = 1'b1;
    end

    if (wb_cyc_i && wb_stb_i && !seq_r.wbAck) begin
      seq_nxt.wbAck = 1'b1;
      unique case (wb_adr_i)
        ces_pkg::REG_STATUS: seq_nxt.wbDat = seq_r.status;
        ces_pkg::REG_LINK: seq_nxt.wbDat = seq_r.link[curBank];
        ces_pkg::REG_SAVED: seq_nxt.wbDat = seq_r.saved[curBank];
        ces_pkg::REG_CAUSE: seq_nxt.wbDat = {26'h0, seq_r.chainFiq, seq_r.kind, seq_r.state};
        default: seq_nxt.wbDat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= '0;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  assign fetchAddr = seq_r.fetchAddr;
  assign fetchValid = seq_r.fetchValid;
  assign currentStatusWord = seq_r.status;
  assign excEntry = seq_r.excEntry;
  assign excKind = seq_r.kind;
  assign wb_dat_o = seq_r.wbDat;
  assign wb_ack_o = seq_r.wbAck;

  // Cycles a fast request has waited while enabled and not yet vectored
  logic [5:0] fiqWait;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fiqWait <= 6'h0;
    end else if (fastIrqRequestLow || seq_r.status[ces_pkg::ST_F_BIT] ||
                 (seq_r.fetchValid && seq_r.fetchAddr == ces_pkg::VEC_FIQ)) begin
      fiqWait <= 6'h0;
    end else if (fiqWait != 6'h3f) begin
      fiqWait <= fiqWait + 6'h1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_swtrap_entry: assert property (
    excEntry && excKind == ces_pkg::EXC_SWTRAP && resetInputActiveLow |=>
      ##[0:3] (fetchValid && fetchAddr == ces_pkg::VEC_SWTRAP &&
               currentStatusWord[4:0] == ces_pkg::MODE_SVC))
    else $error("software trap did not vector to supervisor handler");
  chk_undef_entry: assert property (
    excEntry && excKind == ces_pkg::EXC_UNDEF |->
      currentStatusWord[4:0] == ces_pkg::MODE_UND)
    else $error("undefined trap did not enter undefined mode");
  chk_vector_map: assert property (
    fetchValid && $past(seq_r.state) == ces_pkg::ST_ENTRY && $past(resetInputActiveLow) |->
      fetchAddr == {27'h0, excKind, 2'b00})
    else $error("vector address does not match exception kind");
  chk_dabt_first: assert property (
    seq_r.state == ces_pkg::ST_RUN && dabtIn && resetInputActiveLow |=>
      excEntry && excKind == ces_pkg::EXC_DABT)
    else $error("data abort lost priority");
  chk_dabt_fiq_chain: assert property (
    excEntry && excKind == ces_pkg::EXC_DABT && seq_r.chainFiq && resetInputActiveLow ##1
      resetInputActiveLow |=> (excEntry && excKind == ces_pkg::EXC_FIQ))
    else $error("data abort did not chain into fast interrupt");
  chk_fiq_latency: assert property (
    fiqWait <= 6'(ces_pkg::FIQ_LAT_MAX))
    else $error("fast interrupt latency exceeded");
  chk_min_latency: assert property (
    $fell(fastIrqRequestLow) |->
      !(fetchValid && fetchAddr == ces_pkg::VEC_FIQ)[*4])
    else $error("interrupt vectored faster than minimum latency");
  chk_reset_walk: assert property (
    !$past(resetInputActiveLow) && $past(seq_r.state) == ces_pkg::ST_HOLD |->
      fetchValid && fetchAddr == $past(fetchAddr) + ces_pkg::STEP_FULL)
    else $error("held reset did not walk fetch address");
  chk_reset_release: assert property (
    seq_r.state == ces_pkg::ST_HOLD && resetInputActiveLow && !seq_r.wbAck |=>
      fetchValid && fetchAddr == ces_pkg::VEC_RESET &&
      currentStatusWord[7:0] == {2'b11, 1'b0, ces_pkg::MODE_SVC} &&
      seq_r.link[ces_pkg::BANK_SVC] == $past(fetchAddr))
    else $error("reset release sequence wrong");
  chk_trap_return: assert property (
    seq_r.state == ces_pkg::ST_RUN && resetInputActiveLow && !dabtIn && !fiqPend &&
    !irqPend && insn.valid && !insn.pabt && insnCls == ces_pkg::CLS_DATAPROC &&
    isReturn(insn.word) && curBank != ces_pkg::BANK_NONE |=>
      currentStatusWord == $past(seq_r.saved[curBank]) && fetchValid)
    else $error("trap return did not restore saved status");
  chk_fiq_masks: assert property (
    excEntry && excKind == ces_pkg::EXC_FIQ |->
      currentStatusWord[ces_pkg::ST_I_BIT] && !currentStatusWord[ces_pkg::ST_T_BIT])
    else $error("fast interrupt entry left masks or state wrong");

  cov_dabt_chain: cover property (excEntry && excKind == ces_pkg::EXC_DABT && seq_r.chainFiq);
  cov_irq_entry: cover property (excEntry && excKind == ces_pkg::EXC_IRQ);
  cov_trap_return: cover property (seq_r.state == ces_pkg::ST_RUN && insn.valid &&
                                   isReturn(insn.word) ##1 fetchValid);
  cov_reset_hold: cover property (!resetInputActiveLow [*3] ##1 resetInputActiveLow);

endmodule // ces_exception_sequencer
`default_nettype wire

// ---- dv/ces_far_side.sv ----
// Model of the interrupt controller, abort source and core reset generator
`timescale 1ns/100ps
`default_nettype none
module ces_far_side (
  // Clock
  input wire logic clock,
  // Requests toward the sequencer
  output logic fastIrqRequestLow,
  output logic normalIrqRequestLow,
  output logic dabtIn,
  output logic [31:0] dabtPc,
  output logic resetInputActiveLow
);
  initial begin
    fastIrqRequestLow = 1'b1;
    normalIrqRequestLow = 1'b1;
    dabtIn = 1'b0;
    dabtPc = 32'h5a5a_a5a5;
    resetInputActiveLow = 1'b1;
  end
  // Interrupt levels stay put until the caller changes them
  task automatic set_irq(input logic fast, input logic lvl);
    @(posedge clock);
    if (fast) fastIrqRequestLow <= lvl;
    else normalIrqRequestLow <= lvl;
  endtask
  // One-cycle abort; the address is scrambled once no longer valid
  task automatic abort_at(input logic [31:0] pc);
    @(posedge clock);
    dabtIn <= 1'b1;
    dabtPc <= pc;
    @(posedge clock);
    dabtIn <= 1'b0;
    dabtPc <= ~pc;
  endtask
  task automatic hold_reset(input int n);
    @(posedge clock);
    resetInputActiveLow <= 1'b0;
    repeat (n) @(posedge clock);
    resetInputActiveLow <= 1'b1;
  endtask
endmodule // ces_far_side
`default_nettype wire

// ---- dv/cpu_exception_sequencer_tb.sv ----
// Self-checking bench of the exception sequencer
`timescale 1ns/100ps
`default_nettype none
module cpu_exception_sequencer_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  ces_pkg::ces_insn_t insn = '0;
  logic fastIrqRequestLow, normalIrqRequestLow, dabtIn, resetInputActiveLow;
  logic [31:0] dabtPc, fetchAddr, currentStatusWord, wb_dat_o, rd, a;
  logic fetchValid, excEntry, wb_ack_o;
  ces_pkg::ces_exc_t excKind;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  int n_errors = 0, compares = 0, n;
  always #4 clock = ~clock;
  ces_far_side i_src (.clock(clock), .fastIrqRequestLow(fastIrqRequestLow),
    .normalIrqRequestLow(normalIrqRequestLow), .dabtIn(dabtIn), .dabtPc(dabtPc),
    .resetInputActiveLow(resetInputActiveLow));
  ces_exception_sequencer i_dut (.clock(clock), .rst_n(rst_n),
    .resetInputActiveLow(resetInputActiveLow), .insn(insn), .dabtIn(dabtIn),
    .dabtPc(dabtPc), .fastIrqRequestLow(fastIrqRequestLow),
    .normalIrqRequestLow(normalIrqRequestLow), .fetchAddr(fetchAddr),
    .fetchValid(fetchValid), .currentStatusWord(currentStatusWord), .excEntry(excEntry),
    .excKind(excKind), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic single cycle; ack is read as the edge samples it
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) check(32'h0000_0bad, 32'h0000_0000);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // Waits for the next fetch redirect and compares its address
  task automatic wait_fetch(input logic [31:0] ea);
    #1;
    n = 0;
    while (fetchValid !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(fetchValid, 1'b1);
    check(fetchAddr, ea);
  endtask
  task automatic offer(input logic [31:0] w, input logic [31:0] p);
    @(posedge clock);
    insn.valid <= 1'b1;
    insn.word <= w;
    insn.pc <= p;
    @(posedge clock);
    insn.valid <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    check(fetchAddr, ces_pkg::VEC_RESET);
    check({excEntry, fetchValid}, 2'b11);
    check(currentStatusWord[7:0], 8'hd3);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0000_0000);
    wb(1'b0, ces_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0000_00d3);
    offer(32'hef00_0000, 32'h0000_0100);
    wait_fetch(ces_pkg::VEC_SWTRAP);
    check({excKind, currentStatusWord[4:0]}, {ces_pkg::EXC_SWTRAP, ces_pkg::MODE_SVC});
    wb(1'b0, ces_pkg::REG_LINK, 32'h0);
    check(rd, 32'h0000_0104);
    offer(32'he1b0_f00e, 32'h0000_0008);
    wait_fetch(32'h0000_0104);
    check(currentStatusWord, 32'h0000_00d3);
    offer(32'he000_00d1, 32'h0000_0180);
    repeat (4) begin
      @(posedge clock);
      #1;
      check(fetchValid, 1'b0);
    end
    offer(32'he600_0010, 32'h0000_0200);
    wait_fetch(ces_pkg::VEC_UNDEF);
    check(currentStatusWord[4:0], ces_pkg::MODE_UND);
    insn.pabt <= 1'b1;
    offer(32'he1a0_0000, 32'h0000_0240);
    insn.pabt <= 1'b0;
    wait_fetch(ces_pkg::VEC_PABT);
    check(currentStatusWord[4:0], ces_pkg::MODE_ABT);
    wb(1'b1, ces_pkg::REG_STATUS, 32'h0000_0013);
    i_src.set_irq(1'b0, 1'b0);
    wait_fetch(ces_pkg::VEC_IRQ);
    check(n, ces_pkg::IRQ_LAT_MIN);
    check(currentStatusWord[7:0], 8'h92);
    wb(1'b0, ces_pkg::REG_SAVED, 32'h0);
    check(rd, 32'h0000_0013);
    i_src.set_irq(1'b0, 1'b1);
    insn.busy <= 1'b1;
    i_src.set_irq(1'b1, 1'b0);
    repeat (5) begin
      @(posedge clock);
      #1;
      check(fetchValid, 1'b0);
    end
    i_src.abort_at(32'h0000_0300);
    #1;
    check({excEntry, excKind}, {1'b1, ces_pkg::EXC_DABT});
    wait_fetch(ces_pkg::VEC_FIQ);
    check(currentStatusWord[7:0], 8'hd1);
    wb(1'b0, ces_pkg::REG_LINK, 32'h0);
    check(rd, 32'h0000_0014);
    insn.busy <= 1'b0;
    i_src.set_irq(1'b1, 1'b1);
    fork
      i_src.hold_reset(4);
    join_none
    repeat (3) @(posedge clock);
    #1;
    a = fetchAddr;
    @(posedge clock);
    #1;
    check(fetchAddr, a + 32'h0000_0004);
    repeat (2) @(posedge clock);
    #1;
    check({fetchAddr, currentStatusWord[7:0]}, {ces_pkg::VEC_RESET, 8'hd3});
    wb(1'b0, ces_pkg::REG_LINK, 32'h0);
    check(rd, a + 32'h0000_0008);
    wb(1'b0, ces_pkg::REG_SAVED, 32'h0);
    check(rd, 32'h0000_00d1);
    test_done;
  end
endmodule // cpu_exception_sequencer_tb
`default_nettype wire
